// ===== pfos_pkg.sv
// pfos_pkg: constants and types for the primary fault output sequencer
// assumes a 10 MHz core clock; intervals are built from a 1 ms tick
// Overview of operation
// RULE_01: no fault: fault pin released, pull-up high
// RULE_02: fault: fault pin actively pulled low
// RULE_03: undervoltage: 40 ms low, then 40 ms high
// RULE_04: cleared during sequence: stay released afterwards
// RULE_05: still present after sequence: hold low
// RULE_06: after persisting fault clears, wait 80 ms
// RULE_07: controller supplies pull-up, 5 to 15 V
// RULE_08: controller may leave fault line unconnected
// RULE_09: no half-bridge mode, channels fully independent
// RULE_10: undervoltage forces both channels off
// RULE_11: intervals from ms tick, restarted per state
package pfos_pkg;
    localparam int CLK_HZ = 10000000;
    localparam int TICK_MS_NS = 1000000;
    localparam int CLK_PERIOD_NS = 1000000000 / CLK_HZ;
    localparam int CYC_PER_MS = TICK_MS_NS / CLK_PERIOD_NS;
    localparam int REPORT_MS = 40;
    localparam int GAP_MS = 40;
    localparam int BLOCK_MS = 80;
    localparam int MS_CNT_W = 8;

    typedef enum logic [2:0] {
        PFOS_IDLE,
        PFOS_REPORT,
        PFOS_GAP,
        PFOS_HOLD,
        PFOS_BLOCK
    } pfos_state_t;
endpackage : pfos_pkg

// ===== pfos_ms_tick.sv
// pfos_ms_tick: restartable prescaler giving a one-cycle pulse every millisecond
// assumes clk at the package clock rate and synchronous active-high rst
`timescale 1ns/1ps
`default_nettype none
module pfos_ms_tick
    import pfos_pkg::*;
#(
    parameter int DIV = CYC_PER_MS
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // timebase
    input wire logic restart,
    output logic tick
);
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } pfos_tick_t;

    pfos_tick_t st_ff;
    pfos_tick_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (restart)
        begin
            nxt_st.cnt = 16'h0000; // [RULE_11]
        end
        else if (st_ff.cnt == 16'(DIV - 1))
        begin
            nxt_st.cnt = 16'h0000;
            nxt_st.tick = 1'b1;
        end
        else
        begin
            nxt_st.cnt = st_ff.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign tick = st_ff.tick;
endmodule : pfos_ms_tick
`default_nettype wire

// ===== pfos_seq.sv
// pfos_seq: open-drain fault output sequencer and channel gating
// assumes uv_fault already filtered and synchronous to clk
// the fault pin is open-drain: only a low is ever driven
`timescale 1ns/1ps
`default_nettype none
module pfos_seq
    import pfos_pkg::*;
#(
    parameter int REPORT_TICKS = REPORT_MS,
    parameter int GAP_TICKS = GAP_MS,
    parameter int BLOCK_TICKS = BLOCK_MS,
    parameter int DIV = CYC_PER_MS
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // primary supply monitor
    input wire logic uv_fault,
    // optical drive inputs
    input wire logic opt_in_a,
    input wire logic opt_in_b,
    // channel commands
    output logic gate_on_a,
    output logic gate_on_b,
    // open-drain fault pin
    input wire logic fault_i,
    output logic fault_o,
    output logic fault_oe_n
);
    typedef struct packed {
        pfos_state_t state;
        logic [MS_CNT_W-1:0] ms;
        logic oe_n;
        logic gate_a;
        logic gate_b;
    } pfos_seq_st_t;

    pfos_seq_st_t st_ff;
    pfos_seq_st_t nxt_st;
    logic tick;
    logic restart;

    // timer restarts whenever the state changes
    assign restart = (nxt_st.state != st_ff.state); // [RULE_11]

    pfos_ms_tick #(
        .DIV(DIV)
    ) u_tick (
        .clk(clk),
        .rst(rst),
        .restart(restart),
        .tick(tick)
    );

    always_comb
    begin
        nxt_st = st_ff;
        if (tick)
        begin
            nxt_st.ms = st_ff.ms + 8'h01;
        end
        case (st_ff.state)
            PFOS_IDLE:
            begin
                if (uv_fault)
                begin
                    nxt_st.state = PFOS_REPORT; // [RULE_03]
                end
            end
            PFOS_REPORT:
            begin
                if (tick && st_ff.ms == 8'(REPORT_TICKS - 1))
                begin
                    nxt_st.state = PFOS_GAP; // [RULE_03]
                end
            end
            PFOS_GAP:
            begin
                if (tick && st_ff.ms == 8'(GAP_TICKS - 1))
                begin
                    // [RULE_04] [RULE_05]
                    nxt_st.state = uv_fault ? PFOS_HOLD : PFOS_IDLE;
                end
            end
            PFOS_HOLD:
            begin
                if (!uv_fault)
                begin
                    nxt_st.state = PFOS_BLOCK; // [RULE_06]
                end
            end
            PFOS_BLOCK:
            begin
                // a new undervoltage during blocking keeps the line low and restarts the wait
                if (uv_fault)
                begin
                    nxt_st.state = PFOS_HOLD;
                end
                else if (tick && st_ff.ms == 8'(BLOCK_TICKS - 1))
                begin
                    nxt_st.state = PFOS_IDLE; // [RULE_06]
                end
            end
            default:
            begin
                nxt_st.state = PFOS_IDLE;
            end
        endcase
        if (nxt_st.state != st_ff.state)
        begin
            nxt_st.ms = '0; // [RULE_11]
        end
        // low driven in report, hold and block; released otherwise
        nxt_st.oe_n = !(nxt_st.state == PFOS_REPORT || nxt_st.state == PFOS_HOLD
            || nxt_st.state == PFOS_BLOCK); // [RULE_01] [RULE_02]
        // each channel follows its own input; no interlock
        nxt_st.gate_a = opt_in_a && !uv_fault; // [RULE_09] [RULE_10]
        nxt_st.gate_b = opt_in_b && !uv_fault; // [RULE_09] [RULE_10]
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_ff <= '{state: PFOS_IDLE, ms: 8'h00, oe_n: 1'b1, gate_a: 1'b0, gate_b: 1'b0};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // fault_i is not needed: an unconnected line does not alter the sequence
    assign fault_o = 1'b0;
    assign fault_oe_n = st_ff.oe_n;
    assign gate_on_a = st_ff.gate_a;
    assign gate_on_b = st_ff.gate_b;

    property p_report_len;
        @(posedge clk) disable iff (rst)
        $rose(st_ff.state == PFOS_REPORT) |-> !fault_oe_n [*8];
    endproperty
    a_report_len: assert property (p_report_len) else $error("report low too short"); // [RULE_03]

    property p_idle_released;
        @(posedge clk) disable iff (rst)
        (st_ff.state == PFOS_IDLE) |-> fault_oe_n;
    endproperty
    a_idle_released: assert property (p_idle_released) else $error("idle not released"); // [RULE_01]

    property p_uv_drives_low;
        @(posedge clk) disable iff (rst)
        (st_ff.state == PFOS_IDLE && uv_fault) |=> !fault_oe_n && fault_o == 1'b0;
    endproperty
    a_uv_drives_low: assert property (p_uv_drives_low) else $error("fault not driven low"); // [RULE_02]

    sequence s_gap_end_clear;
        st_ff.state == PFOS_GAP && restart && !uv_fault;
    endsequence
    property p_gap_clear;
        @(posedge clk) disable iff (rst)
        s_gap_end_clear |=> fault_oe_n && st_ff.state == PFOS_IDLE;
    endproperty
    a_gap_clear: assert property (p_gap_clear) else $error("released line relowered"); // [RULE_04]

    sequence s_gap_end_fault;
        st_ff.state == PFOS_GAP && restart && uv_fault;
    endsequence
    property p_gap_hold;
        @(posedge clk) disable iff (rst)
        s_gap_end_fault |=> !fault_oe_n;
    endproperty
    a_gap_hold: assert property (p_gap_hold) else $error("persisting fault not held low"); // [RULE_05]

    property p_block_low;
        @(posedge clk) disable iff (rst)
        (st_ff.state == PFOS_HOLD && !uv_fault) |=> !fault_oe_n [*4];
    endproperty
    a_block_low: assert property (p_block_low) else $error("blocking wait missing"); // [RULE_06]

    property p_uv_gates_off;
        @(posedge clk) disable iff (rst)
        uv_fault |=> !gate_on_a && !gate_on_b;
    endproperty
    a_uv_gates_off: assert property (p_uv_gates_off) else $error("channel on during uv"); // [RULE_10]

    property p_independent;
        @(posedge clk) disable iff (rst)
        (opt_in_a && opt_in_b && !uv_fault) |=> gate_on_a && gate_on_b;
    endproperty
    a_independent: assert property (p_independent) else $error("channels interlocked"); // [RULE_09]

    property p_timer_restart;
        @(posedge clk) disable iff (rst)
        restart |=> st_ff.ms == 8'h00;
    endproperty
    a_timer_restart: assert property (p_timer_restart) else $error("timer not restarted"); // [RULE_11]

    property p_gap_released;
        @(posedge clk) disable iff (rst)
        $rose(st_ff.state == PFOS_GAP) |-> fault_oe_n [*8];
    endproperty
    a_gap_released: assert property (p_gap_released) else $error("gap not released"); // [RULE_03]

    property p_hold_low;
        @(posedge clk) disable iff (rst)
        (st_ff.state == PFOS_HOLD) |-> !fault_oe_n;
    endproperty
    a_hold_low: assert property (p_hold_low) else $error("hold not driven low"); // [RULE_05]

    sequence s_block_end;
        st_ff.state == PFOS_BLOCK && restart && !uv_fault;
    endsequence
    property p_block_release;
        @(posedge clk) disable iff (rst)
        s_block_end |=> fault_oe_n && st_ff.state == PFOS_IDLE;
    endproperty
    a_block_release: assert property (p_block_release) else $error("line not released"); // [RULE_06]

    property p_single_channel;
        @(posedge clk) disable iff (rst)
        (opt_in_a && !opt_in_b && !uv_fault) |=> gate_on_a && !gate_on_b;
    endproperty
    a_single_channel: assert property (p_single_channel) else $error("channel coupling"); // [RULE_09]
endmodule : pfos_seq
`default_nettype wire

// ===== pfos_ctrl_model.sv
// pfos_ctrl_model: far-end controller with a pull-up on the fault line
// assumes the open-drain pin is split into fault_o and fault_oe_n
`timescale 1ns/1ps
`default_nettype none
module pfos_ctrl_model
(
    // open-drain pin from the device
    input wire logic fault_o,
    input wire logic fault_oe_n,
    // resolved line as seen at the far end
    output logic fault_line
);
    // released pin reads the pull-up level; the controller may ignore it
    assign fault_line = fault_oe_n ? 1'b1 : fault_o;
endmodule : pfos_ctrl_model
`default_nettype wire

// ===== primary_fault_output_sequencer_bench.sv
// primary_fault_output_sequencer_bench: directed checks of the fault sequencer
// assumes pfos_seq with a shortened tick so each interval lasts a few cycles
`timescale 1ns/1ps
`default_nettype none
module primary_fault_output_sequencer_bench;
    import pfos_pkg::*;
    localparam int DIV = 4;
    localparam int REP = 3;
    localparam int GAP = 3;
    localparam int BLK = 5;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic uv_fault = 1'b0;
    logic opt_in_a = 1'b0;
    logic opt_in_b = 1'b0;
    logic gate_on_a, gate_on_b, fault_o, fault_oe_n, fault_line;
    int fails = 0;
    int cmp_count = 0;
    int n;
    always #50 clk = ~clk;
    pfos_seq #(.REPORT_TICKS(REP), .GAP_TICKS(GAP), .BLOCK_TICKS(BLK), .DIV(DIV)) DUT (
        .clk(clk), .rst(rst), .uv_fault(uv_fault), .opt_in_a(opt_in_a),
        .opt_in_b(opt_in_b), .gate_on_a(gate_on_a), .gate_on_b(gate_on_b),
        .fault_i(fault_line), .fault_o(fault_o), .fault_oe_n(fault_oe_n));
    pfos_ctrl_model ctrl (.fault_o(fault_o), .fault_oe_n(fault_oe_n), .fault_line(fault_line));

    task stop_test;
        $display("counts: %0d compares, %0d mismatches", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // tick phase is not visible at the pins, so a small slack is allowed
    task check_len(input int seen, input int nom);
        check((seen >= nom - 3 && seen <= nom + 3) ? nom : seen, nom);
    endtask : check_len

    task run_len(input logic lvl, input int lim, output int cnt);
        cnt = 0;
        while (fault_line === lvl && cnt < lim)
        begin
            @(negedge clk);
            cnt++;
        end
        if (cnt >= lim)
        begin
            check(cnt, lim - 1);
            stop_test();
        end
    endtask : run_len

    task t_idle;
        @(posedge clk);
        opt_in_a <= 1'b1;
        opt_in_b <= 1'b0;
        repeat (2) @(negedge clk);
        check(fault_line, 1'b1);
        check(fault_oe_n, 1'b1);
        check({gate_on_a, gate_on_b}, 2'b10);
        @(posedge clk);
        opt_in_a <= 1'b0;
        opt_in_b <= 1'b1;
        repeat (2) @(negedge clk);
        check({gate_on_a, gate_on_b}, 2'b01);
        $display("test idle done");
    endtask : t_idle

    task t_short;
        @(posedge clk);
        opt_in_a <= 1'b1;
        uv_fault <= 1'b1;
        @(posedge clk);
        uv_fault <= 1'b0;
        @(negedge clk);
        check(fault_line, 1'b0);
        run_len(1'b0, 40, n);
        check_len(n, REP * DIV);
        repeat (GAP * DIV + 20)
        begin
            @(negedge clk);
            check(fault_line, 1'b1);
        end
        $display("test short fault done");
    endtask : t_short

    task t_hold;
        @(posedge clk);
        uv_fault <= 1'b1;
        @(negedge clk);
        run_len(1'b1, 6, n);
        run_len(1'b0, 40, n);
        check_len(n, REP * DIV);
        run_len(1'b1, 40, n);
        check_len(n, GAP * DIV);
        repeat (30) @(negedge clk);
        check(fault_line, 1'b0);
        check({gate_on_a, gate_on_b}, 2'b00);
        @(posedge clk);
        uv_fault <= 1'b0;
        @(negedge clk);
        run_len(1'b0, 60, n);
        check_len(n, BLK * DIV);
        repeat (10) @(negedge clk);
        check(fault_line, 1'b1);
        $display("test held fault done");
    endtask : t_hold

    // undervoltage returning inside the blocking wait must keep the line low
    task t_rearm;
        @(posedge clk);
        uv_fault <= 1'b1;
        @(negedge clk);
        run_len(1'b1, 6, n);
        run_len(1'b0, 40, n);
        check_len(n, REP * DIV);
        run_len(1'b1, 40, n);
        check_len(n, GAP * DIV);
        @(posedge clk);
        uv_fault <= 1'b0;
        repeat (8) @(negedge clk);
        check(fault_line, 1'b0);
        @(posedge clk);
        uv_fault <= 1'b1;
        repeat (30) @(negedge clk);
        check(fault_line, 1'b0);
        check({gate_on_a, gate_on_b}, 2'b00);
        @(posedge clk);
        uv_fault <= 1'b0;
        @(negedge clk);
        run_len(1'b0, 60, n);
        check_len(n, BLK * DIV);
        repeat (10) @(negedge clk);
        check(fault_line, 1'b1);
        $display("test rearmed fault done");
    endtask : t_rearm

    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_idle();
        t_short();
        t_hold();
        t_rearm();
        stop_test();
    end
endmodule : primary_fault_output_sequencer_bench
`default_nettype wire
